// ### rtl/timer_cfg.svh
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define ADDR_COUNT 4'h0
`define ADDR_OPTION 4'h4
`define ADDR_STATUS 4'h8
`define ADDR_MASK 4'hC

// ----------------------------------------------------------------
// option, status and mask register fields and reset values
// ----------------------------------------------------------------
`define OPT_CS_BIT 5
`define OPT_SE_BIT 4
`define OPT_PSA_BIT 3
`define OPT_RESET 8'hFF
`define STAT_OVF_BIT 0
`define MASK_RESET 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define WRITE_HOLD_CYCLES 2'h2

`endif

// ### rtl/timer_pkg.sv
package timer_pkg;
    typedef enum logic [0:0] {
        source_instr = 1'b0,
        source_pin = 1'b1
    } source_type;
endpackage

// ### rtl/eight_bit_timer.sv
// Summary of operation
// RULE_01: one 8-bit count register, software readable and writable.
// RULE_02: source select 0 counts each instruction cycle, prescaler permitting.
// RULE_03: counting suppressed for two cycles after a count write.
// RULE_04: source select 1 counts edges of the external input pin.
// RULE_05: polarity 1 counts falling edges, polarity 0 rising edges.
// RULE_06: one prescaler, serving either timer or watchdog, never both.
// RULE_07: assignment bit 0 gives prescaler to timer, 1 to watchdog.
// RULE_08: eight timer ratios 1:2 to 1:256 from 3-bit rate field.
// RULE_09: rate n divides by two to the power n plus one.
// RULE_10: timer runs 1:1 only when prescaler belongs to watchdog.
// RULE_11: prescaler count never readable or writable by software.
// RULE_12: with prescaler on timer, count write clears prescaler.
// RULE_13: with prescaler on watchdog, watchdog clear clears prescaler.
// RULE_14: software follows fixed order when moving prescaler to watchdog.
// RULE_15: shared port pin two feeds the timer external count input.
// RULE_16: every rollover FFh to 00h sets overflow flag; software clears.
// RULE_17: external input synchronised on the instruction clock.
// RULE_18: count and prescaler frozen while the processor sleeps.
`include "timer_cfg.svh"

module eight_bit_timer #(
    parameter int PRESCALE_WIDTH = 8
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic response_error,
    input wire logic port_pin_two,
    input wire logic watchdog_clear_instr,
    input wire logic sleeping,
    output logic watchdog_tick,
    output logic irq
);

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic ack_reg;
    wire access = (read | write) & ~ack_reg;
    wire lane0 = byteenable[0];
    wire hit_count = address == `ADDR_COUNT;
    wire hit_option = address == `ADDR_OPTION;
    wire hit_status = address == `ADDR_STATUS;
    wire hit_mask = address == `ADDR_MASK;
    wire mapped = hit_count | hit_option | hit_status | hit_mask;
    wire wr_count = access & write & hit_count & lane0;
    wire wr_option = access & write & hit_option & lane0;
    wire wr_mask = access & write & hit_mask & lane0;
    wire rd_status = access & read & hit_status;

    // one wait cycle, answer on the second edge
    assign waitrequest = (read | write) & ~ack_reg;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] eight_bit_count_reg; // RULE_01
    logic [7:0] option_reg;
    logic [7:0] mask_reg;
    logic overflow_flag;
    logic [1:0] hold_reg;
    logic [PRESCALE_WIDTH-1:0] prescale_reg; // RULE_06 RULE_11
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic [31:0] readdata_reg;
    logic err_reg;

    wire clock_source_select = option_reg[`OPT_CS_BIT];
    wire edge_polarity_select = option_reg[`OPT_SE_BIT];
    wire prescaler_assign = option_reg[`OPT_PSA_BIT];
    wire [2:0] prescale_rate = option_reg[2:0];
    wire overflow_irq_enable = mask_reg[`STAT_OVF_BIT];

    // ----------------------------------------------------------------
    // count source
    // ----------------------------------------------------------------
    // pin is double-synchronised; third stage only feeds the edge detect
    wire rise = sync2_reg & ~sync3_reg;
    wire fall = ~sync2_reg & sync3_reg;
    wire pin_edge = edge_polarity_select ? fall : rise; // RULE_05
    wire source_tick = (timer_pkg::source_type'(clock_source_select) == timer_pkg::source_pin)
        ? pin_edge : 1'b1; // RULE_02 RULE_04 RULE_15 RULE_17

    // prescaler advances on the selected source when on the timer, else every cycle
    wire to_timer = ~prescaler_assign; // RULE_07
    wire prescale_step = (to_timer ? source_tick : 1'b1) & ~sleeping; // RULE_18
    wire [PRESCALE_WIDTH-1:0] prescale_inc = prescale_reg + 1'b1;
    // tap n rises once every 2^(n+1) prescaler steps
    wire tap_done = prescale_inc[prescale_rate] & ~prescale_reg[prescale_rate]; // RULE_08 RULE_09
    wire timer_tick = to_timer ? (prescale_step & tap_done)
        : (source_tick & ~sleeping); // RULE_10
    wire prescale_clear = (to_timer & wr_count)
        | (prescaler_assign & watchdog_clear_instr); // RULE_12 RULE_13
    wire count_step = timer_tick & (hold_reg == 2'h0); // RULE_03
    wire rollover = count_step & (eight_bit_count_reg == 8'hFF);

    assign watchdog_tick = prescaler_assign & prescale_step & tap_done; // RULE_06

    // ----------------------------------------------------------------
    // next values
    // ----------------------------------------------------------------
    wire [7:0] count_next = wr_count ? writedata[7:0]
        : count_step ? eight_bit_count_reg + 8'h01 : eight_bit_count_reg;
    wire [1:0] hold_next = wr_count ? `WRITE_HOLD_CYCLES
        : (hold_reg != 2'h0) ? hold_reg - 2'h1 : 2'h0; // RULE_03
    wire [PRESCALE_WIDTH-1:0] prescale_next = prescale_clear ? '0
        : prescale_step ? prescale_inc : prescale_reg;
    // set wins over the read-clear
    wire flag_next = rollover | (overflow_flag & ~rd_status); // RULE_16
    wire [31:0] read_mux = hit_count ? {24'h000000, eight_bit_count_reg}
        : hit_option ? {24'h000000, option_reg}
        : hit_status ? {31'h00000000, overflow_flag}
        : hit_mask ? {24'h000000, mask_reg} : 32'h00000000;

    // ----------------------------------------------------------------
    // flops
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= port_pin_two;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            eight_bit_count_reg <= 8'h00;
            hold_reg <= 2'h0;
            prescale_reg <= '0;
            overflow_flag <= 1'b0;
        end else begin
            eight_bit_count_reg <= count_next;
            hold_reg <= hold_next;
            prescale_reg <= prescale_next;
            overflow_flag <= flag_next;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            option_reg <= `OPT_RESET;
            mask_reg <= `MASK_RESET;
        end else begin
            if (wr_option) begin
                option_reg <= writedata[7:0];
            end
            if (wr_mask) begin
                mask_reg <= {7'h00, writedata[0]};
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack_reg <= 1'b0;
            readdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end else begin
            ack_reg <= access;
            err_reg <= access & ~mapped;
            if (access & read) begin
                readdata_reg <= read_mux;
            end
        end
    end

    assign readdata = readdata_reg;
    assign response_error = err_reg;
    assign irq = overflow_flag & overflow_irq_enable; // RULE_16

endmodule // eight_bit_timer

// ### verif/timer_checker_sva.sv
module timer_checker (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic response_error,
    input wire logic watchdog_tick,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] opt_reg;
    logic mask_reg;
    wire taken = write && waitrequest && byteenable[0];
    wire ans = read && !waitrequest;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // shadows move on the taken edge, as the block's registers do
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            opt_reg <= 8'hFF;
            mask_reg <= 1'b0;
        end else begin
            opt_reg <= (taken && address == 4'h4) ? writedata[7:0] : opt_reg;
            mask_reg <= (taken && address == 4'hC) ? writedata[0] : mask_reg;
        end
    end
    req_waits_a: assert property ($rose(read || write) |-> waitrequest)
        else $error("request answered without a wait");
    one_wait_a: assert property (waitrequest |=> !waitrequest)
        else $error("wait longer than one cycle");
    upper_zero_a: assert property (ans |-> readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    unmapped_err_a: assert property (ans && address[1:0] != 2'h0 |-> readdata == 32'h0 && response_error)
        else $error("unmapped read not refused");
    mapped_ok_a: assert property (ans && address[1:0] == 2'h0 |-> !response_error)
        else $error("mapped read flagged as error");
    option_read_a: assert property (ans && address == 4'h4 |-> readdata[7:0] == opt_reg)
        else $error("option readback differs");
    irq_masked_a: assert property (irq |-> mask_reg)
        else $error("interrupt while masked");
    tick_owner_a: assert property (watchdog_tick |-> opt_reg[3])
        else $error("watchdog tick while prescaler on timer");
    cover property (irq);
    cover property (watchdog_tick);
    cover property (ans && response_error);
endmodule // timer_checker

bind eight_bit_timer timer_checker timer_checker_i (.clock(clock), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .response_error(response_error),
    .watchdog_tick(watchdog_tick), .irq(irq));

// ### verif/event_source.sv
module event_source (
    input wire logic clock,
    input wire logic start,
    input wire logic [3:0] toggles,
    output logic pin_level,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] left_reg = 4'h0;
    logic [1:0] gap_reg = 2'h0;
    assign busy = left_reg != 4'h0;
    initial pin_level = 1'b0;
    // four cycles per level, well above the input sync latency
    always @(posedge clock) begin
        if (start) begin
            left_reg <= toggles;
        end else if (busy) begin
            gap_reg <= gap_reg + 2'h1;
            if (gap_reg == 2'h3) begin
                pin_level <= ~pin_level;
                left_reg <= left_reg - 4'h1;
            end
        end
    end
endmodule // event_source

// ### verif/eight_bit_timer_bench.sv
module eight_bit_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic wd_clear = 1'b0;
    logic sleeping = 1'b0;
    logic start = 1'b0;
    logic [31:0] readdata;
    logic waitrequest, response_error, pin, watchdog_tick, irq, busy;
    logic [7:0] q, v;
    int err_count = 0;
    int tests_run = 0;
    // reads four divider periods apart must differ by 4
    logic [7:0] opt_rows [9] = '{8'hC8, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
    int gap_rows [9] = '{1, 5, 13, 29, 61, 125, 253, 509, 1021};
    eight_bit_timer eight_bit_timer_i (.clock(clock), .nrst(nrst), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .response_error(response_error),
        .port_pin_two(pin), .watchdog_clear_instr(wd_clear), .sleeping(sleeping),
        .watchdog_tick(watchdog_tick), .irq(irq));
    event_source event_source_i (.clock(clock), .start(start), .toggles(4'h5),
        .pin_level(pin), .busy(busy));
    always #50 clock = ~clock;
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= {24'h0, d};
        // look at waitrequest mid-cycle, where it has settled, then take the answer edge
        do begin
            @(negedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        @(posedge clock);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) begin
            err_count++;
            final_report();
        end
    endtask
    task automatic pin_edges(input logic [7:0] opt);
        int n;
        n = 0;
        bus(1'b1, 4'h4, opt);
        bus(1'b0, 4'h0, 8'h0);
        v = q;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (busy !== 1'b0 && n < 60);
        if (n >= 60) begin
            err_count++;
            final_report();
        end
        repeat (6) @(posedge clock);
        bus(1'b0, 4'h0, 8'h0);
    endtask
    initial begin
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        bus(1'b0, 4'h4, 8'h0);
        check(q, 8'hFF);
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, 4'h4, opt_rows[i]);
            bus(1'b0, 4'h0, 8'h0);
            v = q;
            repeat (gap_rows[i]) @(posedge clock);
            bus(1'b0, 4'h0, 8'h0);
            check(q - v, 8'h04);
        end
        $display("rate table done");
        bus(1'b1, 4'hC, 8'h01);
        bus(1'b1, 4'h4, 8'hC8);
        bus(1'b1, 4'h0, 8'hFE);
        bus(1'b0, 4'h0, 8'h0);
        check(q, 8'hFE);
        repeat (2) @(posedge clock);
        bus(1'b0, 4'h0, 8'h0);
        check(q, 8'h03);
        check({7'h0, irq}, 8'h01);
        bus(1'b0, 4'h8, 8'h0);
        check(q, 8'h01);
        bus(1'b0, 4'h8, 8'h0);
        check(q, 8'h00);
        $display("hold and overflow done");
        byteenable <= 4'h0;
        bus(1'b1, 4'h4, 8'h00);
        byteenable <= 4'hF;
        bus(1'b0, 4'h4, 8'h0);
        check(q, 8'hC8);
        bus(1'b0, 4'h2, 8'h0);
        check(q, 8'h00);
        $display("access done");
        sleeping <= 1'b1;
        wd_clear <= 1'b1;
        bus(1'b0, 4'h0, 8'h0);
        wd_clear <= 1'b0;
        v = q;
        repeat (5) @(posedge clock);
        bus(1'b0, 4'h0, 8'h0);
        check(q, v);
        sleeping <= 1'b0;
        $display("sleep done");
        pin_edges(8'hE8);
        check(q - v, 8'h03);
        pin_edges(8'hF8);
        check(q - v, 8'h03);
        $display("counter done");
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        bus(1'b0, 4'h4, 8'h0);
        check(q, 8'hFF);
        bus(1'b0, 4'h8, 8'h0);
        check(q, 8'h00);
        $display("reset done");
        final_report();
    end
endmodule // eight_bit_timer_bench
